// File: hw/chan_bank_cfg.svh
`ifndef CHAN_BANK_CFG_SVH
`define CHAN_BANK_CFG_SVH

`define ADDR_CONFIG 8'h00
`define ADDR_CHIP_IDENTIFIER 8'h01
`define ADDR_INDEX 8'h05
`define ADDR_POWER 8'h08
`define ADDR_CLKDIV 8'h0b
`define ADDR_SHUFFLE 8'h0c
`define ADDR_XFER 8'hff

`define RST_CONFIG 8'h18
`define RST_INDEX 8'hcf
`define RST_POWER 8'h00
`define RST_CLKDIV 8'h00
`define RST_SHUFFLE 8'h01

`define MASK_INDEX 8'hcf
`define MASK_POWER_GLB 8'h20
`define MASK_POWER_LOC 8'h03
`define MASK_CLKDIV 8'h3f
`define MASK_SHUFFLE 8'h03

`define CFG_LSB_HI 6
`define CFG_LSB_LO 1
`define CFG_SRST_HI 5
`define CFG_SRST_LO 2
`define XFER_BIT 0
`define INSTR_READ_BIT 15
`define INSTR_BITS 5'd16
`define LEN_STREAM 2'b11

// arbitrary identification value
`define CHIP_IDENTIFIER_DEFAULT 8'h5a
`define NUM_CHAN 4

`define H_CMD 8'h00
`define H_STATUS 8'h04
`define H_CFG 8'h08
`define CLK_MHZ 200
`define SCLK_HALF_NS 50
`define SCLK_HALF_CYC ((`SCLK_HALF_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: hw/chan_bank_pkg.sv
package chan_bank_pkg;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SHIFT = 3'b010,
    HS_END = 3'b100
  } host_state_e;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

endpackage

// File: hw/serial_link_if.sv
`timescale 1ns/1ps
interface serial_link_if;
  logic sclk;
  logic csb;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdio;

  // undriven line floats high through a pull-up
  assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);

  modport host (
    output sclk,
    output csb,
    output sdio_host_o,
    output sdio_host_oe,
    input sdio
  );

  modport device (
    input sclk,
    input csb,
    input sdio,
    output sdio_dev_o,
    output sdio_dev_oe
  );
endinterface

// File: hw/shadow_byte.sv
`timescale 1ns/1ps
module shadow_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restore,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic xfer,
  output logic [7:0] shadow_q,
  output logic [7:0] active_q
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_q <= RESET_VAL & MASK;
      active_q <= RESET_VAL & MASK;
    end else if (restore) begin
      shadow_q <= RESET_VAL & MASK;
      active_q <= RESET_VAL & MASK;
    end else begin
      if (wr_en) begin
        shadow_q <= wr_data & MASK;
      end
      // copy takes the staged value from before any write in this cycle
      if (xfer) begin
        active_q <= shadow_q;
      end
    end
  end

endmodule

// File: hw/serial_reg_bank.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - every register is one byte, msb first
// - host writes zeros to unused bits
// - host never writes fully open addresses
// - reset loads every register default
// - function range writes stage in shadow
// - writing one to transfer register commands transfer
// - transfer copies all shadows same cycle
// - transfer bit clears itself
// - each channel owns its local copies
// - local access reaches selected channels only
// - multi-select write updates every selected channel
// - host selects one channel before reading
// - multi-select read returns first channel
// - globals ignore the channel index
// - msb first until configured otherwise
`include "chan_bank_cfg.svh"
module serial_reg_bank
  import chan_bank_pkg::*;
#(
  parameter int NUM_CHAN = `NUM_CHAN,
  parameter logic [7:0] CHIP_IDENTIFIER = `CHIP_IDENTIFIER_DEFAULT
) (
  input wire logic hclk,
  input wire logic hresetn,
  serial_link_if.device link,
  output logic lsb_first,
  output logic [1:0] out_port_en,
  output logic pd_pin_standby,
  output logic [2:0] clk_phase,
  output logic [2:0] clk_div_ratio,
  output logic [NUM_CHAN-1:0][1:0] power_mode,
  output logic [NUM_CHAN-1:0][1:0] shuffle_mode
);

  logic [1:0] sclk_sync;
  logic [1:0] csb_sync;
  logic [1:0] sdio_sync;
  logic sclk_d;

  logic [4:0] instr_cnt_reg;
  logic [14:0] instr_sr_reg;
  logic [6:0] data_sr_reg;
  logic [2:0] data_bit_reg;
  logic [1:0] len_reg;
  logic [1:0] bytes_done_reg;
  logic is_read_reg;
  logic addr_ok_reg;
  logic frame_done_reg;
  logic [7:0] addr_reg;
  logic [7:0] rd_byte_reg;
  logic sdio_o_reg;
  logic sdio_oe_reg;

  logic lsb_first_reg;
  logic srst_reg;
  logic [7:0] index_reg;
  logic xfer_reg;

  logic [7:0] power_glb_sh;
  logic [7:0] power_glb_act;
  logic [7:0] clkdiv_sh;
  logic [7:0] clkdiv_act;
  logic [7:0] power_loc_sh [NUM_CHAN];
  logic [7:0] power_loc_act [NUM_CHAN];
  logic [7:0] shuffle_sh [NUM_CHAN];
  logic [7:0] shuffle_act [NUM_CHAN];
  logic [1:0] first_ch;
  logic [7:0] rd_mux;

  // pins are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_sync <= 2'b00;
      csb_sync <= 2'b11;
      sdio_sync <= 2'b00;
      sclk_d <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], link.sclk};
      csb_sync <= {csb_sync[0], link.csb};
      sdio_sync <= {sdio_sync[0], link.sdio};
      sclk_d <= sclk_sync[1];
    end
  end

  wire frame_on = ~csb_sync[1];
  wire sclk_rise = frame_on & sclk_sync[1] & ~sclk_d;
  wire sclk_fall = frame_on & ~sclk_sync[1] & sclk_d;
  wire sdio_bit = sdio_sync[1];
  wire in_instr = instr_cnt_reg != `INSTR_BITS;

  wire [15:0] instr_next = {instr_sr_reg, sdio_bit};
  wire [15:0] instr_w = lsb_first_reg ? rev16(instr_next) : instr_next;
  wire [7:0] data_next = {data_sr_reg, sdio_bit};
  wire [7:0] data_w = lsb_first_reg ? rev8(data_next) : data_next;
  wire data_rise = sclk_rise & ~in_instr & ~frame_done_reg;
  wire byte_last = data_rise & (data_bit_reg == 3'd7);
  wire wr_stb = byte_last & ~is_read_reg & addr_ok_reg;
  wire last_byte = (len_reg != `LEN_STREAM) & (bytes_done_reg == len_reg);

  wire [7:0] mux_addr = in_instr ? instr_w[7:0] : addr_reg + 8'd1;
  wire mux_ok = in_instr ? (instr_w[12:8] == 5'd0) : addr_ok_reg;

  // serial frame: 16-bit instruction then bytes, address counting up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_cnt_reg <= 5'd0;
      instr_sr_reg <= 15'h0000;
      data_sr_reg <= 7'h00;
      data_bit_reg <= 3'd0;
      len_reg <= 2'b00;
      bytes_done_reg <= 2'b00;
      is_read_reg <= 1'b0;
      addr_ok_reg <= 1'b0;
      frame_done_reg <= 1'b0;
      addr_reg <= 8'h00;
      rd_byte_reg <= 8'h00;
      sdio_o_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end else if (!frame_on) begin
      instr_cnt_reg <= 5'd0;
      data_bit_reg <= 3'd0;
      bytes_done_reg <= 2'b00;
      frame_done_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end else begin
      if (sclk_rise && in_instr) begin
        instr_sr_reg <= instr_next[14:0];
        instr_cnt_reg <= instr_cnt_reg + 5'd1;
        if (instr_cnt_reg == 5'd15) begin
          is_read_reg <= instr_w[`INSTR_READ_BIT];
          len_reg <= instr_w[14:13];
          addr_reg <= instr_w[7:0];
          addr_ok_reg <= instr_w[12:8] == 5'd0;
          rd_byte_reg <= rd_mux;
        end
      end
      if (data_rise) begin
        data_sr_reg <= data_next[6:0];
        data_bit_reg <= data_bit_reg + 3'd1;
        if (data_bit_reg == 3'd7) begin
          addr_reg <= addr_reg + 8'd1;
          rd_byte_reg <= rd_mux;
          bytes_done_reg <= bytes_done_reg + 2'd1;
          frame_done_reg <= last_byte;
        end
      end
      // drive only after the host has let go, on the falling edge
      if (sclk_fall) begin
        sdio_oe_reg <= is_read_reg & ~in_instr & ~frame_done_reg;
        sdio_o_reg <= lsb_first_reg ? rd_byte_reg[data_bit_reg] : rd_byte_reg[3'd7 - data_bit_reg];
      end
    end
  end

  wire hit_cfg = addr_reg == `ADDR_CONFIG;
  wire hit_index = addr_reg == `ADDR_INDEX;
  wire hit_xfer = addr_reg == `ADDR_XFER;
  wire hit_power = addr_reg == `ADDR_POWER;
  wire hit_clkdiv = addr_reg == `ADDR_CLKDIV;
  wire hit_shuffle = addr_reg == `ADDR_SHUFFLE;
  wire [NUM_CHAN-1:0] chan_sel = index_reg[NUM_CHAN-1:0];
  wire chan_any = |chan_sel;

  // unshadowed registers act when the byte completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsb_first_reg <= 1'b0;
      srst_reg <= 1'b0;
      index_reg <= `RST_INDEX;
      xfer_reg <= 1'b0;
    end else begin
      if (wr_stb && hit_cfg) begin
        lsb_first_reg <= data_w[`CFG_LSB_HI] | data_w[`CFG_LSB_LO];
      end
      srst_reg <= wr_stb & hit_cfg & (data_w[`CFG_SRST_HI] | data_w[`CFG_SRST_LO]);
      if (srst_reg) begin
        index_reg <= `RST_INDEX;
      end else if (wr_stb && hit_index) begin
        index_reg <= data_w & `MASK_INDEX;
      end
      // high for exactly one cycle, so it clears itself
      xfer_reg <= wr_stb & hit_xfer & data_w[`XFER_BIT];
    end
  end

  shadow_byte #(.RESET_VAL(`RST_POWER), .MASK(`MASK_POWER_GLB)) u_power_glb (
    .hclk(hclk),
    .hresetn(hresetn),
    .restore(srst_reg),
    .wr_en(wr_stb & hit_power),
    .wr_data(data_w),
    .xfer(xfer_reg),
    .shadow_q(power_glb_sh),
    .active_q(power_glb_act)
  );

  shadow_byte #(.RESET_VAL(`RST_CLKDIV), .MASK(`MASK_CLKDIV)) u_clkdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .restore(srst_reg),
    .wr_en(wr_stb & hit_clkdiv),
    .wr_data(data_w),
    .xfer(xfer_reg),
    .shadow_q(clkdiv_sh),
    .active_q(clkdiv_act)
  );

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    // one copy per channel, written when its select bit is set
    shadow_byte #(.RESET_VAL(`RST_POWER), .MASK(`MASK_POWER_LOC)) u_power_loc (
      .hclk(hclk),
      .hresetn(hresetn),
      .restore(srst_reg),
      .wr_en(wr_stb & hit_power & chan_sel[ch]),
      .wr_data(data_w),
      .xfer(xfer_reg),
      .shadow_q(power_loc_sh[ch]),
      .active_q(power_loc_act[ch])
    );

    shadow_byte #(.RESET_VAL(`RST_SHUFFLE), .MASK(`MASK_SHUFFLE)) u_shuffle (
      .hclk(hclk),
      .hresetn(hresetn),
      .restore(srst_reg),
      .wr_en(wr_stb & hit_shuffle & chan_sel[ch]),
      .wr_data(data_w),
      .xfer(xfer_reg),
      .shadow_q(shuffle_sh[ch]),
      .active_q(shuffle_act[ch])
    );

    assign power_mode[ch] = power_loc_act[ch][1:0];
    assign shuffle_mode[ch] = shuffle_act[ch][1:0];
  end

  // lowest selected channel wins a read
  always_comb begin
    first_ch = 2'd0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (chan_sel[i]) begin
        first_ch = 2'(i);
      end
    end
  end

  wire [7:0] power_loc_rd = chan_any ? power_loc_sh[first_ch] : 8'h00;
  wire [7:0] shuffle_rd = chan_any ? shuffle_sh[first_ch] : 8'h00;
  wire [7:0] cfg_rd = `RST_CONFIG | ({7'h00, lsb_first_reg} << `CFG_LSB_HI) | ({7'h00, lsb_first_reg} << `CFG_LSB_LO);

  // reads show the staged copy; unmapped addresses read zero
  assign rd_mux = !mux_ok ? 8'h00 :
    (mux_addr == `ADDR_CONFIG) ? cfg_rd :
    (mux_addr == `ADDR_CHIP_IDENTIFIER) ? CHIP_IDENTIFIER :
    (mux_addr == `ADDR_INDEX) ? index_reg :
    (mux_addr == `ADDR_XFER) ? {7'h00, xfer_reg} :
    (mux_addr == `ADDR_POWER) ? (power_glb_sh | power_loc_rd) :
    (mux_addr == `ADDR_CLKDIV) ? clkdiv_sh :
    (mux_addr == `ADDR_SHUFFLE) ? shuffle_rd : 8'h00;

  assign link.sdio_dev_o = sdio_o_reg;
  assign link.sdio_dev_oe = sdio_oe_reg;
  assign lsb_first = lsb_first_reg;
  assign out_port_en = index_reg[7:6];
  assign pd_pin_standby = power_glb_act[5];
  assign clk_phase = clkdiv_act[5:3];
  assign clk_div_ratio = clkdiv_act[2:0];

endmodule

// File: hw/serial_host_ctrl.sv
`timescale 1ns/1ps
`include "chan_bank_cfg.svh"
module serial_host_ctrl
  import chan_bank_pkg::*;
#(
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  serial_link_if.host link
);

  host_state_e state_reg;
  logic [1:0] sdio_sync;
  logic [7:0] div_reg;
  logic ap_wr_reg;
  logic [7:0] ap_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic lsb_reg;
  logic [23:0] tx_reg;
  logic rd_reg;
  logic [4:0] bit_idx_reg;
  logic [7:0] rx_reg;
  logic [7:0] rd_data_reg;
  logic sclk_reg;
  logic csb_reg;
  logic sdio_o_reg;
  logic sdio_oe_reg;

  wire busy = state_reg != HS_IDLE;
  wire ap_take = hsel & hready & htrans[1];
  wire tick = busy & (div_reg == 8'(HALF_CYC - 1));
  wire cmd_wr = ap_wr_reg & (ap_addr_reg == `H_CMD) & ~busy;
  // upper address bits always zero; data bits pass as software gives them
  wire [15:0] instr = {hwdata[16], 2'b00, 5'b00000, hwdata[15:8]};
  wire [23:0] tx_w = lsb_reg ? {rev16(instr), rev8(hwdata[7:0])} : {instr, hwdata[7:0]};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_val = (ra == `H_STATUS) ? {16'h0000, rd_data_reg, 7'h00, busy} :
    (ra == `H_CFG) ? {31'h00000000, lsb_reg} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      lsb_reg <= 1'b0;
      sdio_sync <= 2'b11;
    end else begin
      ap_wr_reg <= ap_take & hwrite;
      ap_addr_reg <= haddr[7:0];
      if (ap_take && !hwrite) begin
        hrdata_reg <= rd_val;
      end
      // host order must follow what the device was told
      if (ap_wr_reg && ap_addr_reg == `H_CFG) begin
        lsb_reg <= hwdata[0];
      end
      sdio_sync <= {sdio_sync[0], link.sdio};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 8'h00;
    end else if (!busy || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= HS_IDLE;
      tx_reg <= 24'h000000;
      rd_reg <= 1'b0;
      bit_idx_reg <= 5'd0;
      rx_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      sclk_reg <= 1'b0;
      csb_reg <= 1'b1;
      sdio_o_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        HS_IDLE: begin
          if (cmd_wr) begin
            tx_reg <= tx_w;
            rd_reg <= hwdata[16];
            bit_idx_reg <= 5'd0;
            csb_reg <= 1'b0;
            sdio_o_reg <= tx_w[23];
            sdio_oe_reg <= 1'b1;
            state_reg <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (tick && !sclk_reg) begin
            sclk_reg <= 1'b1;
            rx_reg <= {rx_reg[6:0], sdio_sync[1]};
          end else if (tick) begin
            sclk_reg <= 1'b0;
            if (bit_idx_reg == 5'd23) begin
              sdio_oe_reg <= 1'b0;
              state_reg <= HS_END;
            end else begin
              bit_idx_reg <= bit_idx_reg + 5'd1;
              sdio_o_reg <= tx_reg[5'd22 - bit_idx_reg];
              // release the line for the device's data byte
              sdio_oe_reg <= ~(rd_reg & (bit_idx_reg >= 5'd15));
            end
          end
        end
        HS_END: begin
          // stay busy a half period with csb high, so frames never touch
          if (tick && !csb_reg) begin
            csb_reg <= 1'b1;
            rd_data_reg <= lsb_reg ? rev8(rx_reg) : rx_reg;
          end else if (tick) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0 & hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign link.sclk = sclk_reg;
  assign link.csb = csb_reg;
  assign link.sdio_host_o = sdio_o_reg;
  assign link.sdio_host_oe = sdio_oe_reg;

endmodule

// File: tb/chan_link_checker_assertions.sv
`timescale 1ns/1ps
module chan_link_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic sdio
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic sclk_q;
  logic [5:0] rise_cnt;

  // rising edges of sclk seen inside the current frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      rise_cnt <= 6'h0;
    end else begin
      sclk_q <= sclk;
      rise_cnt <= csb ? 6'h0 : rise_cnt + {5'h0, sclk && !sclk_q};
    end
  end

  a_bus_free: assert property (!(sdio_host_oe && sdio_dev_oe))
    else $error("sdio driven by both ends");
  a_sclk_idle: assert property (csb |-> !sclk)
    else $error("sclk moves outside a frame");
  a_frame_open: assert property ($fell(csb) |-> sdio_host_oe && !sclk)
    else $error("frame opened without host data");
  a_half_period: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk ##1 sclk ##1 !sclk)
    else $error("sclk high phase not ten cycles");
  a_host_hold: assert property (sclk && $past(sclk) && sdio_host_oe |-> $stable(sdio_host_o))
    else $error("host data moved while sclk high");
  a_dev_hold: assert property ($rose(sclk) && sdio_dev_oe |=> ($stable(sdio_dev_o) || !sdio_dev_oe)[*8])
    else $error("device data moved while sclk high");
  a_csb_gap: assert property ($rose(csb) |-> csb[*8])
    else $error("frames too close together");
  a_frame_bits: assert property ($rose(csb) |-> rise_cnt == 6'd24)
    else $error("frame is not instruction plus one byte");
  a_dev_quiet: assert property ($rose(csb) |-> ##[0:6] !sdio_dev_oe)
    else $error("device still drives after frame end");

  c_frame: cover property ($fell(csb));
  c_readback: cover property ($rose(sdio_dev_oe));
  c_full_frame: cover property ($rose(csb) && rise_cnt == 6'd24);
endmodule

// File: tb/shadowed_channel_register_bank_test.sv
`timescale 1ns/1ps
`include "chan_bank_cfg.svh"
module shadowed_channel_register_bank_test
  import chan_bank_pkg::*;
;
  localparam logic [7:0] CHIP_IDENTIFIER = 8'h3c; // arbitrary value
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire lsb_first;
  wire pd_pin_standby;
  wire [1:0] out_port_en;
  wire [2:0] clk_phase;
  wire [2:0] clk_div_ratio;
  wire [3:0][1:0] power_mode;
  wire [3:0][1:0] shuffle_mode;
  wire [25:0] act = {lsb_first, out_port_en, pd_pin_standby, clk_phase, clk_div_ratio, power_mode, shuffle_mode};
  int err_count = 0;
  int n_tests = 0;

  always #2.5 hclk = ~hclk;

  serial_link_if link();

  serial_host_ctrl #(.HALF_CYC(10)) u_serial_host_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link));

  serial_reg_bank #(.NUM_CHAN(4), .CHIP_IDENTIFIER(CHIP_IDENTIFIER)) u_serial_reg_bank (.hclk(hclk), .hresetn(hresetn),
    .link(link), .lsb_first(lsb_first), .out_port_en(out_port_en), .pd_pin_standby(pd_pin_standby),
    .clk_phase(clk_phase), .clk_div_ratio(clk_div_ratio), .power_mode(power_mode), .shuffle_mode(shuffle_mode));

  chan_link_checker u_chan_link_checker (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk), .csb(link.csb),
    .sdio_host_o(link.sdio_host_o), .sdio_host_oe(link.sdio_host_oe), .sdio_dev_o(link.sdio_dev_o),
    .sdio_dev_oe(link.sdio_dev_oe), .sdio(link.sdio));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // single word transfer; waits on hready rather than assuming zero waits
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wait_idle;
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h1;
    while (link.csb !== 1'b0 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    while (r[0] !== 1'b0 && n < 1000) begin
      ahb(1'b0, `H_STATUS, 32'h0, r);
      n++;
    end
    chk("busy", 32'h0, {31'h0, r[0]});
  endtask

  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, `H_CMD, {16'h0, a, d}, r);
    wait_idle();
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    ahb(1'b1, `H_CMD, {15'h0, 1'b1, a, 8'h00}, r);
    wait_idle();
    ahb(1'b0, `H_STATUS, 32'h0, r);
    chk(name, {24'h0, exp}, {24'h0, r[15:8]});
  endtask

  task automatic ochk(input logic [25:0] exp);
    chk("outputs", {6'h0, exp}, {6'h0, act});
  endtask

  task automatic t_defaults;
    ochk({1'b0, 2'b11, 1'b0, 3'd0, 3'd0, 8'h00, 8'h55});
    rchk("config", 8'h00, 8'h18);
    rchk("index", 8'h05, 8'hcf);
    rchk("xfer", 8'hff, 8'h00);
    rchk("shuffle", 8'h0c, 8'h01);
    $display("test defaults done");
  endtask

  task automatic t_ident;
    logic [31:0] r;
    rchk("ident", 8'h01, CHIP_IDENTIFIER);
    dwr(8'h01, 8'ha5);
    rchk("ident kept", 8'h01, CHIP_IDENTIFIER);
    ahb(1'b1, 8'h0c, 32'hffff_ffff, r);
    ahb(1'b0, 8'h0c, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test ident done");
  endtask

  task automatic t_shadow;
    dwr(8'h0b, 8'h2a);
    dwr(8'h08, 8'h22);
    ochk({1'b0, 2'b11, 1'b0, 3'd0, 3'd0, 8'h00, 8'h55});
    rchk("shadow", 8'h0b, 8'h2a);
    dwr(8'hff, 8'h01);
    ochk({1'b0, 2'b11, 1'b1, 3'd5, 3'd2, 8'haa, 8'h55});
    rchk("xfer clear", 8'hff, 8'h00);
    $display("test shadow done");
  endtask

  task automatic t_local;
    dwr(8'h05, 8'hc6);
    dwr(8'h0c, 8'h00);
    dwr(8'hff, 8'h01);
    ochk({1'b0, 2'b11, 1'b1, 3'd5, 3'd2, 8'haa, 8'h41});
    rchk("multi read", 8'h0c, 8'h00);
    for (int ch = 0; ch < 4; ch++) begin
      dwr(8'h05, 8'hc0 | (8'h01 << ch));
      rchk("channel", 8'h0c, (ch == 1 || ch == 2) ? 8'h00 : 8'h01);
    end
    dwr(8'h05, 8'h41);
    dwr(8'h0b, 8'h07);
    dwr(8'hff, 8'h01);
    ochk({1'b0, 2'b01, 1'b1, 3'd0, 3'd7, 8'haa, 8'h41});
    dwr(8'h05, 8'hc8);
    rchk("global", 8'h0b, 8'h07);
    rchk("mixed", 8'h08, 8'h22);
    $display("test local done");
  endtask

  // device flips order at byte end, so host order follows right after
  task automatic t_order;
    logic [31:0] r;
    dwr(8'h00, 8'h5a);
    ochk({1'b1, 2'b11, 1'b1, 3'd0, 3'd7, 8'haa, 8'h41});
    ahb(1'b1, `H_CFG, 32'h1, r);
    rchk("config lsb", 8'h00, 8'h5a);
    rchk("ident lsb", 8'h01, CHIP_IDENTIFIER);
    dwr(8'h00, 8'h18);
    ahb(1'b1, `H_CFG, 32'h0, r);
    ochk({1'b0, 2'b11, 1'b1, 3'd0, 3'd7, 8'haa, 8'h41});
    rchk("config msb", 8'h00, 8'h18);
    $display("test order done");
  endtask

  // soft reset reloads index, staged and active copies, not the order
  task automatic t_srst;
    dwr(8'h00, 8'h3c);
    ochk({1'b0, 2'b11, 1'b0, 3'd0, 3'd0, 8'h00, 8'h55});
    rchk("soft index", 8'h05, 8'hcf);
    rchk("soft shadow", 8'h0b, 8'h00);
    $display("test soft reset done");
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    t_defaults();
    t_ident();
    t_shadow();
    t_local();
    t_order();
    t_srst();
    finish_test();
  end

  // about 40 frames of some 500 cycles each fit well inside this
  initial begin
    #300us;
    err_count++;
    $display("[ERR] run expected done seen timeout");
    finish_test();
  end
endmodule
